/* rtl/rtc_consts.svh */
// Constants for the real-time clock and calendar block: port addresses,
// register indices, field positions, reset values and timing counts.
// Assumes it is included by bare name from the package and the design.
// Function
// - Host access blocked until both interface bits set.
// - Index port selects location, data port accesses it.
// - Time 00-09, control 0A-0D, RAM 0E-3F, 7F.
// - Twelve-hour hours carry PM in top bit.
// - Divide crystal ticks down to one-second update.
// - Rate field picks one of thirteen divider taps.
// - Divider reset code holds chain at zero.
// - First update and periodic event half-phased.
// - Format bit selects binary or BCD encoding.
// - Hour-format bit selects 12 or 24 hours.
// - Daylight saving skips two to three in April.
// - Daylight saving repeats one o'clock late October.
// - Leap-year February has twenty-nine days.
// - Software avoids time access during update.
// - Freeze bit aborts and blocks time updates.
// - No update for 999 ms after update ends.
// - Pending flag rises 244 us before update.
// - Periodic event leaves half period plus margin; rate codes 3 and 4 leave half a period only, code 5 lands on the update tick.
// - Matching alarm sets flag and drives interrupt.
// - Alarm byte with top two bits set matches.
// - Date alarm only in lockout, binary, 01-1F.
// - Rate code zero none, codes 3-15 doubling periods, codes 1 and 2 repeat 8 and 9.
// - Divider codes: off, normal, test, reset.
// - Flag register read clears flags, new events survive.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define PORT_INDEX      16'h0070
`define PORT_DATA       16'h0071
`define PORT_BUS_CTL1   16'hEF00
`define PORT_BUS_CTL2   16'hEF01
`define BUS_CTL_EN_BIT  2

`define IDX_SEC         8'h00
`define IDX_ASEC        8'h01
`define IDX_MIN         8'h02
`define IDX_AMIN        8'h03
`define IDX_HOUR        8'h04
`define IDX_AHOUR       8'h05
`define IDX_WDAY        8'h06
`define IDX_MDAY        8'h07
`define IDX_MONTH       8'h08
`define IDX_YEAR        8'h09
`define IDX_CTL_A       8'h0A
`define IDX_CTL_B       8'h0B
`define IDX_FLAGS       8'h0C
`define IDX_STATUS      8'h0D
`define IDX_RAM_FIRST   8'h0E
`define IDX_RAM_LAST    8'h3F
`define IDX_AMDAY       8'h7F
`define RAM_BYTES       50

`define B_FREEZE        7
`define B_PIE           6
`define B_ALARM_IRQ     5
`define B_UIE           4
`define B_BIN           2
`define B_H24           1
`define B_DST           0

`define DIV_NORMAL      3'b010
`define DIV_BITS        15
`define UPDATE_TAP      14
`define AMDAY_MAX       8'h1F

`define RST_CTL_A       7'h00
`define RST_CTL_B       8'h02
`define STATUS_VALUE    8'h80
`define UNMAPPED_DATA   8'h00

`define CRYSTAL_HZ      32768
`define PENDING_US      244
`define PENDING_TICKS   4'(((`PENDING_US * `CRYSTAL_HZ) + 999999) / 1000000)

`endif

/* rtl/rtc_pkg.sv */
// Types shared by the clock block and its bench.
// Assumes the constants header is on the include path.
`include "rtc_consts.svh"
package rtc_pkg;

  // One host I/O request; ports are 16-bit I/O addresses.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } host_req_t;

  // Complete state of the clock block.
  typedef struct packed {
    logic [7:0]                     bus_ctl1;
    logic [7:0]                     bus_ctl2;
    logic [7:0]                     index;
    logic [7:0]                     sec;
    logic [7:0]                     asec;
    logic [7:0]                     min;
    logic [7:0]                     amin;
    logic [7:0]                     hour;
    logic [7:0]                     ahour;
    logic [7:0]                     wday;
    logic [7:0]                     mday;
    logic [7:0]                     month;
    logic [7:0]                     year;
    logic [7:0]                     amday;
    logic [6:0]                     ctla;
    logic [7:0]                     ctlb;
    logic                           pf;
    logic                           af;
    logic                           uf;
    logic                           irq;
    logic [`DIV_BITS-1:0]           div;
    logic                           xtal_prev;
    logic                           xout;
    logic                           update_pending_flag;
    logic [3:0]                     pending_cnt;
    logic                           dst_done;
    logic [7:0]                     rdata;
    logic [`RAM_BYTES-1:0][7:0]     ram;
  } state_t;

endpackage : rtc_pkg

/* rtl/rtc_timekeeper.sv */
// Real-time clock and calendar with index/data host port and backup RAM.
// Assumes the crystal input is already synchronous to clk and far slower,
// and that the host holds wr or rd high for one clk cycle per access.
`include "rtc_consts.svh"
module rtc_timekeeper (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire rtc_pkg::host_req_t host_req,
  output logic [7:0]              host_rdata,
  input  wire logic               crystal_in,
  output logic                    crystal_out,
  input  wire logic               lockout,
  output logic                    rtc_irq_n
);

  rtc_pkg::state_t state_reg;
  rtc_pkg::state_t state_next;

  // Register value to plain binary.
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    return bin ? v : ({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]};
  endfunction : to_bin

  // Plain binary (0-99) to register value.
  function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
    return bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
  endfunction : from_bin

  // Last day of a month; only the two-digit year decides leap years.
  function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
    case (mo)
      8'h02:                      month_len = (yr[1:0] == 2'b00) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: month_len = 8'h1E;
      default:                    month_len = 8'h1F;
    endcase
  endfunction : month_len

  // One alarm byte against its time byte, with the don't-care code.
  function automatic logic alarm_hit(input logic [7:0] a, input logic [7:0] t);
    return (a[7:6] == 2'b11) || (a == t);
  endfunction : alarm_hit

  logic                 tick;
  logic                 running;
  logic                 rtc_en;
  logic                 bin;
  logic                 h24mode;
  logic [3:0]           periodic_rate_select;
  logic [3:0]           tap;
  logic [`DIV_BITS-1:0] rise;
  logic                 do_update;
  logic                 pf_set;
  logic                 af_set;
  logic                 uf_set;
  logic                 flag_clr;
  logic                 date_cmp;
  logic [7:0]           s;
  logic [7:0]           mi;
  logic [7:0]           h;
  logic [7:0]           h12;
  logic [7:0]           d;
  logic [7:0]           mo;
  logic [7:0]           y;
  logic [7:0]           wd;
  logic                 spring;
  logic                 fall;
  logic [7:0]           rd_val;
  logic [7:0]           ram_ix;

  // Next-state logic for the whole block.
  always_comb begin
    state_next = state_reg;
    tick       = crystal_in & ~state_reg.xtal_prev;
    state_next.xtal_prev = crystal_in;
    bin        = state_reg.ctlb[`B_BIN];
    h24mode    = state_reg.ctlb[`B_H24];
    periodic_rate_select = state_reg.ctla[3:0];
    rtc_en     = state_reg.bus_ctl1[`BUS_CTL_EN_BIT] & state_reg.bus_ctl2[`BUS_CTL_EN_BIT];
    // Codes 000 and 001 stop the oscillator; test codes count like normal.
    running    = state_reg.ctla[6:5] != 2'b00;
    do_update  = 1'b0;
    pf_set     = 1'b0;
    af_set     = 1'b0;
    uf_set     = 1'b0;
    flag_clr   = 1'b0;
    spring     = 1'b0;
    fall       = 1'b0;
    rd_val     = `UNMAPPED_DATA;
    ram_ix     = state_reg.index - `IDX_RAM_FIRST;
    s = 8'h00; mi = 8'h00; h = 8'h00; h12 = 8'h00;
    d = 8'h00; mo = 8'h00; y = 8'h00; wd = 8'h00;
    date_cmp   = 1'b0;

    // Divider chain; the reset code pins every stage at zero.
    if (state_reg.ctla[6:5] == 2'b11) begin
      state_next.div = '0;
    end else if (tick && running) begin
      state_next.div = state_reg.div + 1'b1;
    end
    // The crystal is passed back out while the oscillator runs.
    state_next.xout = running & ~crystal_in;
    // A stage rising marks its tap; each first rises half its period in.
    rise = ~state_reg.div & state_next.div;

    // Rate codes 1 and 2 reuse the taps of codes 8 and 9.
    case (periodic_rate_select)
      4'h1:    tap = 4'd6;
      4'h2:    tap = 4'd7;
      default: tap = periodic_rate_select - 4'd2;
    endcase
    pf_set = (periodic_rate_select != 4'h0) && rise[tap];

    // Pending flag goes up at the one-second tap, update follows 244 us later.
    // Periodic taps share this chain; tap 3 (rate code 5) rises on the same tick as the update.
    if (state_reg.ctlb[`B_FREEZE]) begin
      state_next.update_pending_flag = 1'b0;
      state_next.pending_cnt         = 4'h0;
    end else if (rise[`UPDATE_TAP]) begin
      state_next.update_pending_flag = 1'b1;
      state_next.pending_cnt         = `PENDING_TICKS;
    end else if (state_reg.update_pending_flag && tick) begin
      state_next.pending_cnt = state_reg.pending_cnt - 4'h1;
      if (state_reg.pending_cnt == 4'h1) begin
        state_next.update_pending_flag = 1'b0;
        do_update                      = 1'b1;
      end
    end

    // One-second update done in binary, then re-encoded.
    if (do_update) begin
      s   = to_bin(state_reg.sec, bin);
      mi  = to_bin(state_reg.min, bin);
      h12 = to_bin({1'b0, state_reg.hour[6:0]}, bin);
      d   = to_bin(state_reg.mday, bin);
      mo  = to_bin(state_reg.month, bin);
      y   = to_bin(state_reg.year, bin);
      wd  = state_reg.wday;
      if (h24mode) begin
        h = h12;
      end else if (h12 == 8'd12) begin
        h = state_reg.hour[7] ? 8'd12 : 8'd0;
      end else begin
        h = state_reg.hour[7] ? h12 + 8'd12 : h12;
      end
      // Daylight saving checks are made on the 1:59:59 second.
      if (state_reg.ctlb[`B_DST] && s == 8'd59 && mi == 8'd59 && h == 8'd1 && wd == 8'h01) begin
        spring = (mo == 8'd4) && (d <= 8'd7);
        fall   = (mo == 8'd10) && (d >= 8'd25) && !state_reg.dst_done;
      end
      if (s == 8'd59) begin
        s = 8'd0;
        if (mi == 8'd59) begin
          mi = 8'd0;
          if (spring) begin
            h = 8'd3;
          end else if (fall) begin
            h = 8'd1;
            state_next.dst_done = 1'b1;
          end else if (h == 8'd23) begin
            h  = 8'd0;
            wd = (wd >= 8'h07) ? 8'h01 : wd + 8'h01;
            state_next.dst_done = 1'b0;
            if (d >= month_len(mo, y)) begin
              d = 8'd1;
              if (mo >= 8'd12) begin
                mo = 8'd1;
                y  = (y >= 8'd99) ? 8'd0 : y + 8'd1;
              end else begin
                mo = mo + 8'd1;
              end
            end else begin
              d = d + 8'd1;
            end
          end else begin
            h = h + 8'd1;
          end
        end else begin
          mi = mi + 8'd1;
        end
      end else begin
        s = s + 8'd1;
      end
      state_next.sec   = from_bin(s, bin);
      state_next.min   = from_bin(mi, bin);
      state_next.mday  = from_bin(d, bin);
      state_next.month = from_bin(mo, bin);
      state_next.year  = from_bin(y, bin);
      state_next.wday  = wd;
      if (h24mode) begin
        state_next.hour = from_bin(h, bin);
      end else begin
        h12 = (h == 8'd0) ? 8'd12 : (h > 8'd12) ? h - 8'd12 : h;
        h12 = from_bin(h12, bin);
        state_next.hour = {h >= 8'd12, h12[6:0]};
      end
      uf_set = 1'b1;
      // Date alarm joins the compare only in lockout, binary, 01-1F.
      date_cmp = lockout && bin && state_reg.amday != 8'h00
                 && state_reg.amday <= `AMDAY_MAX;
      af_set = alarm_hit(state_reg.asec, state_next.sec)
               && alarm_hit(state_reg.amin, state_next.min)
               && alarm_hit(state_reg.ahour, state_next.hour)
               && (!date_cmp || state_reg.amday == state_next.mday);
    end

    // Read side of the data port.
    case (state_reg.index)
      `IDX_SEC:    rd_val = state_reg.sec;
      `IDX_ASEC:   rd_val = state_reg.asec;
      `IDX_MIN:    rd_val = state_reg.min;
      `IDX_AMIN:   rd_val = state_reg.amin;
      `IDX_HOUR:   rd_val = state_reg.hour;
      `IDX_AHOUR:  rd_val = state_reg.ahour;
      `IDX_WDAY:   rd_val = state_reg.wday;
      `IDX_MDAY:   rd_val = state_reg.mday;
      `IDX_MONTH:  rd_val = state_reg.month;
      `IDX_YEAR:   rd_val = state_reg.year;
      `IDX_CTL_A:  rd_val = {state_reg.update_pending_flag & ~state_reg.ctlb[`B_FREEZE], state_reg.ctla};
      `IDX_CTL_B:  rd_val = state_reg.ctlb;
      `IDX_FLAGS:  rd_val = {state_reg.irq, state_reg.pf, state_reg.af, state_reg.uf, 4'h0};
      `IDX_STATUS: rd_val = `STATUS_VALUE;
      `IDX_AMDAY:  rd_val = state_reg.amday;
      default: begin
        if (state_reg.index >= `IDX_RAM_FIRST && state_reg.index <= `IDX_RAM_LAST) begin
          rd_val = state_reg.ram[ram_ix[5:0]];
        end
      end
    endcase

    // Host port; interface enable bytes are always reachable.
    if (host_req.wr) begin
      if (host_req.addr == `PORT_BUS_CTL1) begin
        state_next.bus_ctl1 = host_req.wdata;
      end else if (host_req.addr == `PORT_BUS_CTL2) begin
        state_next.bus_ctl2 = host_req.wdata;
      end else if (rtc_en && host_req.addr == `PORT_INDEX) begin
        state_next.index = host_req.wdata;
      end else if (rtc_en && !lockout && host_req.addr == `PORT_DATA) begin
        // A host write lands after the update, so software loads win.
        case (state_reg.index)
          `IDX_SEC:   state_next.sec   = host_req.wdata;
          `IDX_ASEC:  state_next.asec  = host_req.wdata;
          `IDX_MIN:   state_next.min   = host_req.wdata;
          `IDX_AMIN:  state_next.amin  = host_req.wdata;
          `IDX_HOUR:  state_next.hour  = host_req.wdata;
          `IDX_AHOUR: state_next.ahour = host_req.wdata;
          `IDX_WDAY:  state_next.wday  = host_req.wdata;
          `IDX_MDAY:  state_next.mday  = host_req.wdata;
          `IDX_MONTH: state_next.month = host_req.wdata;
          `IDX_YEAR:  state_next.year  = host_req.wdata;
          `IDX_CTL_A: state_next.ctla  = host_req.wdata[6:0];
          `IDX_CTL_B: state_next.ctlb  = host_req.wdata;
          `IDX_AMDAY: state_next.amday = host_req.wdata;
          default: begin
            if (state_reg.index >= `IDX_RAM_FIRST && state_reg.index <= `IDX_RAM_LAST) begin
              state_next.ram[ram_ix[5:0]] = host_req.wdata;
            end
          end
        endcase
      end
    end

    // Reads return data one cycle later; disabled or other ports read zero.
    state_next.rdata = `UNMAPPED_DATA;
    if (host_req.rd) begin
      if (host_req.addr == `PORT_BUS_CTL1) begin
        state_next.rdata = state_reg.bus_ctl1;
      end else if (host_req.addr == `PORT_BUS_CTL2) begin
        state_next.rdata = state_reg.bus_ctl2;
      end else if (rtc_en && host_req.addr == `PORT_INDEX) begin
        state_next.rdata = state_reg.index;
      end else if (rtc_en && host_req.addr == `PORT_DATA) begin
        state_next.rdata = rd_val;
        flag_clr = state_reg.index == `IDX_FLAGS;
      end
    end

    // Reading the flag register clears; an event in the same cycle wins.
    state_next.pf  = (state_reg.pf & ~flag_clr) | pf_set;
    state_next.af  = (state_reg.af & ~flag_clr) | af_set;
    state_next.uf  = (state_reg.uf & ~flag_clr) | uf_set;
    state_next.irq = (state_next.pf & state_next.ctlb[`B_PIE])
                   | (state_next.af & state_next.ctlb[`B_ALARM_IRQ])
                   | (state_next.uf & state_next.ctlb[`B_UIE]);
  end

  // State register; time and RAM reset to zero so simulation starts defined.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg      <= '0;
      state_reg.ctla <= `RST_CTL_A;
      state_reg.ctlb <= `RST_CTL_B;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops.
  assign host_rdata  = state_reg.rdata;
  assign crystal_out = state_reg.xout;
  assign rtc_irq_n   = ~state_reg.irq;

endmodule : rtc_timekeeper

/* verif/rtc_host_model.sv */
// Host processor model that speaks the block's one-strobe I/O request port.
// Assumes clk is the block's clock; every access leaves one idle cycle behind it.
`include "rtc_consts.svh"
module rtc_host_model (
  input  wire logic          clk,
  output rtc_pkg::host_req_t host_req,
  input  wire logic [7:0]    host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial host_req = '0;

  // The strobe is dropped only at the edge that takes it, so no access is doubled.
  task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk);
    host_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    host_req.wr <= 1'b0;
  endtask : io_write

  // Read data stands for one cycle after the taking edge; it is sampled just past it.
  task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clk);
    host_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    host_req.rd <= 1'b0;
    #1 data = host_rdata;
  endtask : io_read

  // Both interface enable bytes get bit 2 before the port pair is used.
  task automatic enable_ports();
    io_write(`PORT_BUS_CTL1, 8'h04);
    io_write(`PORT_BUS_CTL2, 8'h04);
  endtask : enable_ports

  // An internal location is reached by its index first, then through the data port.
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] data);
    io_write(`PORT_INDEX, idx);
    io_write(`PORT_DATA, data);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] idx, output logic [7:0] data);
    io_write(`PORT_INDEX, idx);
    io_read(`PORT_DATA, data);
  endtask : reg_read
endmodule : rtc_host_model

/* verif/rtc_timekeeper_props.sv */
// Port checker for the clock block: read answers, port enables, crystal output.
// Assumes it sees only the top ports; enables, index and divider field are shadowed.
`include "rtc_consts.svh"
module rtc_timekeeper_props (
  input wire logic               clk,
  input wire logic               rst,
  input wire rtc_pkg::host_req_t host_req,
  input wire logic [7:0]         host_rdata,
  input wire logic               crystal_in,
  input wire logic               crystal_out,
  input wire logic               lockout,
  input wire logic               rtc_irq_n
);
  logic [7:0] bus_ctl1_reg;
  logic [7:0] bus_ctl2_reg;
  logic [7:0] idx_reg;
  logic [6:0] ctla_reg;
  logic       en;
  logic       osc_off;
  logic       div_normal;

  // Decoded views of the shadow state.
  assign en         = bus_ctl1_reg[2] && bus_ctl2_reg[2];
  assign osc_off    = ctla_reg[6:5] == 2'b00;
  assign div_normal = ctla_reg[6:4] == `DIV_NORMAL;

  // Shadows follow host writes; lockout blocks data writes just as in the block.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_ctl1_reg <= 8'h00;
      bus_ctl2_reg <= 8'h00;
      idx_reg      <= 8'h00;
      ctla_reg     <= 7'h00;
    end else if (host_req.wr) begin
      if (host_req.addr == `PORT_BUS_CTL1) bus_ctl1_reg <= host_req.wdata;
      if (host_req.addr == `PORT_BUS_CTL2) bus_ctl2_reg <= host_req.wdata;
      if (en && host_req.addr == `PORT_INDEX) idx_reg <= host_req.wdata;
      if (en && !lockout && host_req.addr == `PORT_DATA && idx_reg == `IDX_CTL_A) ctla_reg <= host_req.wdata[6:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_data_rd;
    host_req.rd && en && host_req.addr == `PORT_DATA;
  endsequence

  chk_rdata_idle: assert property (!host_req.rd |=> host_rdata == 8'h00)
    else $error("read data not idle after a cycle without read");
  chk_locked_port: assert property (host_req.rd && !en && host_req.addr[15:1] == 15'h0038 |=> host_rdata == 8'h00)
    else $error("port pair answered before enable");
  chk_bus_ctl_readback: assert property (host_req.rd && host_req.addr == `PORT_BUS_CTL1 |=> host_rdata == bus_ctl1_reg)
    else $error("interface enable byte read wrong");
  chk_status_const: assert property (s_data_rd ##0 idx_reg == `IDX_STATUS |=> host_rdata == `STATUS_VALUE)
    else $error("status register read wrong");
  chk_unmapped_zero: assert property (s_data_rd ##0 (idx_reg > `IDX_RAM_LAST && idx_reg != `IDX_AMDAY) |=> host_rdata == 8'h00)
    else $error("unmapped index returned data");
  chk_flags_byte: assert property (s_data_rd ##0 idx_reg == `IDX_FLAGS |=> host_rdata[3:0] == 4'h0 && host_rdata[7] == !$past(rtc_irq_n))
    else $error("flag byte disagrees with interrupt line");
  chk_ctla_readback: assert property (s_data_rd ##0 idx_reg == `IDX_CTL_A |=> host_rdata[6:0] == ctla_reg)
    else $error("divider and rate field read wrong");
  chk_osc_stopped: assert property (osc_off && $past(osc_off) |-> crystal_out == 1'b0)
    else $error("crystal output active while oscillator disabled");
  chk_osc_running: assert property (div_normal && $past(div_normal) |-> crystal_out == !$past(crystal_in))
    else $error("crystal output not inverted input");
endmodule : rtc_timekeeper_props

bind rtc_timekeeper rtc_timekeeper_props props_i (.clk(clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
  .crystal_in(crystal_in), .crystal_out(crystal_out), .lockout(lockout), .rtc_irq_n(rtc_irq_n));

/* verif/rtc_timekeeper_tb_top.sv */
// Top testbench for the clock block: port enable, register map, two full updates.
// Assumes the host model and the bound checker are compiled alongside.
`include "rtc_consts.svh"
module rtc_timekeeper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               crystal_in = 1'b0;
  logic               lockout = 1'b0;
  rtc_pkg::host_req_t host_req;
  logic [7:0]         host_rdata;
  logic               crystal_out;
  logic               rtc_irq_n;
  logic [7:0]         rd;
  int                 miscompares = 0;
  int                 check_count = 0;
  int                 cycle = 0;
  int                 t0;
  logic [7:0] map_idx [7] = '{8'h0E, 8'h3F, 8'h40, 8'h7E, 8'h80, 8'h7F, 8'h0D};
  logic [7:0] map_wr  [7] = '{8'hA5, 8'h5A, 8'h11, 8'h22, 8'h33, 8'h1F, 8'h44};
  logic [7:0] map_exp [7] = '{8'hA5, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h80};
  logic [7:0] tm_set  [10] = '{8'h59, 8'hC0, 8'h59, 8'h00, 8'h23, 8'h00, 8'h07, 8'h28, 8'h02, 8'h04};
  logic [7:0] tm_exp  [10] = '{8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04};

  always #10 clk = ~clk;

  // Crystal toggles every clk, so two half-second waits fit in the run.
  always @(posedge clk) begin
    cycle <= cycle + 1;
    crystal_in <= ~crystal_in;
  end

  rtc_timekeeper uut (.clk(clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata), .crystal_in(crystal_in),
    .crystal_out(crystal_out), .lockout(lockout), .rtc_irq_n(rtc_irq_n));
  rtc_host_model host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // A hang past about one and a half expected run lengths ends the run as failed.
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    host.reg_read(`IDX_STATUS, rd);
    check(rd, 8'h00);
    host.enable_ports();
    host.io_read(`PORT_BUS_CTL1, rd);
    check(rd, 8'h04);
    host.reg_read(`IDX_CTL_B, rd);
    check(rd, `RST_CTL_B);
    $display("test port enable done");
    for (int i = 0; i < 7; i++) begin
      host.reg_write(map_idx[i], map_wr[i]);
      host.reg_read(map_idx[i], rd);
      check(rd, map_exp[i]);
    end
    $display("test register map done");
    // Frozen load of 23:59:59 on 28 Feb of a leap year; date alarm is ignored out of lockout.
    host.reg_write(`IDX_CTL_B, 8'h82);
    host.reg_write(`IDX_CTL_A, 8'h70);
    for (int i = 0; i < 10; i++) begin
      host.reg_write(8'(i), tm_set[i]);
    end
    host.reg_write(`IDX_AMDAY, 8'h05);
    host.reg_write(`IDX_CTL_B, 8'h32);
    host.reg_write(`IDX_CTL_A, 8'h2F);
    t0 = cycle;
    for (int n = 0; n < 70000 && rtc_irq_n !== 1'b0; n++) begin
      @(posedge clk);
    end
    check(8'((cycle - t0) inside {[32776:32792]}), 8'h01);
    host.reg_read(`IDX_FLAGS, rd);
    check(rd, 8'hF0);
    host.reg_read(`IDX_FLAGS, rd);
    check(rd, 8'h00);
    check({7'h00, rtc_irq_n}, 8'h01);
    // Reading right after the update-ended event keeps clear of the next update.
    for (int i = 0; i < 10; i++) begin
      host.reg_read(8'(i), rd);
      check(rd, tm_exp[i]);
    end
    host.reg_read(`IDX_CTL_A, rd);
    check(rd, 8'h2F);
    $display("test first update done");
    // Binary time with don't-care alarms but a missing date; in lockout the date must veto.
    host.reg_write(`IDX_CTL_B, 8'h86);
    host.reg_write(`IDX_CTL_A, 8'h70);
    host.reg_write(`IDX_MDAY, 8'h04);
    for (int i = 1; i < 6; i += 2) begin
      host.reg_write(8'(i), 8'hC0);
    end
    host.reg_write(`IDX_AMDAY, 8'h05);
    host.reg_write(`IDX_CTL_B, 8'h36);
    host.reg_write(`IDX_CTL_A, 8'h20);
    t0 = cycle;
    lockout <= 1'b1;
    host.reg_write(`IDX_RAM_FIRST, 8'h00);
    host.reg_read(`IDX_RAM_FIRST, rd);
    check(rd, 8'hA5);
    for (int n = 0; n < 40000 && rtc_irq_n !== 1'b0; n++) begin
      @(posedge clk);
    end
    check(8'((cycle - t0) inside {[32776:32792]}), 8'h01);
    host.reg_read(`IDX_FLAGS, rd);
    check(rd, 8'h90);
    host.reg_read(`IDX_SEC, rd);
    check(rd, 8'h01);
    $display("test lockout alarm done");
    stop_test();
  end
endmodule : rtc_timekeeper_tb_top
